/* pkg/usm_pkg.sv */
// Behaviour
// R1 - Line status bit 6 set while transmit holding is empty, cleared by writing it.
// R2 - Line status bit 5 set while transmit holding and receive buffer are empty.
// R3 - Line status bit 4 set when serial input stays low beyond longest character.
// R4 - Line status bit 3 raised on a received character with a bad stop bit.
// R5 - Line status bit 2 raised on a received character with a parity failure.
// R6 - Line status bit 1 raised when a new character overwrites an unread one.
// R7 - Line status bit 0 set while receive buffer holds data, cleared by reading.
// R8 - Enable bit 3 lets any of modem status bits 3 to 0 interrupt.
// R9 - Enable bit 2 lets any of line status bits 3 to 0 interrupt.
// R10 - Enable bit 1 interrupts when the transmit buffer empties during transmission.
// R11 - Enable bit 0 interrupts when the receive buffer fills during reception.
// R12 - Ident bit 0 is 1 when idle; bits 2:1 give top source, line 11.
// R13 - Receive full source shows code 10, priority 2, cleared by buffer read.
// R14 - Transmit empty source shows code 01, cleared by holding write or ident read.
// R15 - Loop mode holds serial out high and loops modem outputs to status inputs.
// R16 - Modem control bit 1 drives request-to-send output inverted.
// R17 - Modem control bit 0 drives terminal-ready output inverted.
// R18 - Modem status bit 3 marks a carrier-detect change since last status read.
// R19 - Modem status bit 2 marks ring pin going 0 to 1 since last read.
// R20 - Modem status bit 1 marks a set-ready change since last status read.
// R21 - Modem status bit 0 marks a clear-to-send change since last status read.
// R22 - Framing check looks only at the first stop bit.
// R23 - Parity fault flag is active only while parity is enabled.
// R24 - Modem status bits 7 to 4 show carrier, ring, set-ready, clear-send now.
// R25 - Break, framing, parity and overrun flags clear on a line status read.
package usm_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IID = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX1 = 2;
  localparam int MCR_AUX2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int LCR_STOP = 2;
  localparam int LCR_PAR = 3;
  localparam logic [1:0] IID_LINE = 2'h3;
  localparam logic [1:0] IID_RX = 2'h2;
  localparam logic [1:0] IID_TX = 2'h1;
  localparam logic [1:0] IID_MODEM = 2'h0;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] PINS_RST = 4'hF;
  localparam logic [3:0] STATE_RST = 4'h0;
  // Start bit plus the five-bit minimum word, in bit times.
  localparam logic [3:0] CHAR_BASE = 4'h6;
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic stop_ok;
    logic parity_bad;
  } usm_rx_evt_t;

  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_send;
  } usm_modem_t;
endpackage

/* hw/usm_core.sv */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module usm_core (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  output logic [7:0] rdata_o,
  // Transmit shifter side
  input wire logic tx_take_i,
  input wire logic tx_serial_i,
  output logic [7:0] tx_data_o,
  output logic tx_full_o,
  // Receive shifter side
  input wire usm_pkg::usm_rx_evt_t rx_evt_i,
  input wire logic bit_tick_i,
  output logic rx_serial_o,
  output logic [7:0] line_ctrl_o,
  // Serial and modem pins
  input wire logic serial_in_pin_i,
  input wire usm_pkg::usm_modem_t modem_pins_n_i,
  output logic serial_out_pin_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic aux_output_one_n_o,
  output logic aux_output_two_n_o,
  output logic irq_pending_n_o
);

  // Link group: synchronisers and break detection.
  logic rxd_meta_ff, rxd_sync_ff, rx_serial_ff;
  logic nxt_rx_serial;
  logic [3:0] mdm_meta_ff, mdm_sync_ff;
  logic [3:0] brk_cnt_ff, nxt_brk_cnt;
  logic [3:0] char_limit;
  logic rxd_eff, brk_evt;

  // Register group.
  logic [7:0] tx_data_ff, nxt_tx_data, rx_buf_ff, nxt_rx_buf;
  logic [7:0] lcr_ff, nxt_lcr, rdata_ff, nxt_rdata, rd_mux;
  logic [3:0] ier_ff, nxt_ier, delta_ff, nxt_delta, prev_ff, nxt_prev;
  logic [4:0] mcr_ff, nxt_mcr;
  logic tx_full_ff, nxt_tx_full, rx_avail_ff, nxt_rx_avail;
  logic tx_int_ff, nxt_tx_int;
  logic brk_ff, nxt_brk, frame_ff, nxt_frame;
  logic parity_ff, nxt_parity, over_ff, nxt_over;
  logic txd_ff, rts_n_ff, dtr_n_ff, aux1_n_ff, aux2_n_ff, irq_n_ff;
  logic nxt_txd, nxt_rts_n, nxt_dtr_n, nxt_aux1_n, nxt_aux2_n, nxt_irq_n;
  logic wr_tx, rd_rx, rd_iid, rd_lsr, rd_msr;
  logic line_src, rx_src, tx_src, modem_src, any_src;
  logic [1:0] iid_code;
  logic [3:0] mdm_now, looped, change;
  logic [7:0] lsr_val, msr_val;

  assign wr_tx = wr_stb_i && (addr_i == usm_pkg::ADDR_DATA);
  assign rd_rx = rd_stb_i && (addr_i == usm_pkg::ADDR_DATA);
  assign rd_iid = rd_stb_i && (addr_i == usm_pkg::ADDR_IID);
  assign rd_lsr = rd_stb_i && (addr_i == usm_pkg::ADDR_LSR);
  assign rd_msr = rd_stb_i && (addr_i == usm_pkg::ADDR_MSR);

  // In loop mode the receiver hears the transmitter, not the pin.
  assign rxd_eff = mcr_ff[usm_pkg::MCR_LOOP] ? tx_serial_i
                                              : rxd_sync_ff; // R15

  always_comb begin
    // Longest character: start, word, optional parity, up to two stops.
    char_limit = usm_pkg::CHAR_BASE + {2'h0, lcr_ff[1:0]}
               + {3'h0, lcr_ff[usm_pkg::LCR_PAR]}
               + {3'h0, lcr_ff[usm_pkg::LCR_STOP]} + 4'h1;
    nxt_rx_serial = rxd_eff;
    nxt_brk_cnt = brk_cnt_ff;
    brk_evt = 1'b0;
    if (rxd_eff) begin
      nxt_brk_cnt = usm_pkg::CNT_RST;
    end else if (bit_tick_i && (brk_cnt_ff <= char_limit)) begin
      nxt_brk_cnt = brk_cnt_ff + 4'h1;
      // Fires once per low period, on passing the longest character.
      brk_evt = (brk_cnt_ff == char_limit); // R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
      rx_serial_ff <= 1'b1;
      mdm_meta_ff <= usm_pkg::PINS_RST;
      mdm_sync_ff <= usm_pkg::PINS_RST;
      brk_cnt_ff <= usm_pkg::CNT_RST;
    end else if (ce_i) begin
      rxd_meta_ff <= serial_in_pin_i;
      rxd_sync_ff <= rxd_meta_ff;
      rx_serial_ff <= nxt_rx_serial;
      mdm_meta_ff <= modem_pins_n_i;
      mdm_sync_ff <= mdm_meta_ff;
      brk_cnt_ff <= nxt_brk_cnt;
    end
  end

  // Modem state, asserted high, taken from the pins or from the loop.
  assign looped = {mcr_ff[usm_pkg::MCR_AUX2], mcr_ff[usm_pkg::MCR_AUX1],
                   mcr_ff[usm_pkg::MCR_DTR], mcr_ff[usm_pkg::MCR_RTS]};
  assign mdm_now = mcr_ff[usm_pkg::MCR_LOOP] ? looped : ~mdm_sync_ff; // R15
  // Ring counts only its trailing edge: pin low to high means deasserted.
  assign change = {prev_ff[3] ^ mdm_now[3], // R18
                   prev_ff[2] & ~mdm_now[2], // R19
                   prev_ff[1] ^ mdm_now[1], // R20
                   prev_ff[0] ^ mdm_now[0]}; // R21

  assign lsr_val = {1'b0, ~tx_full_ff, // R1
                    ~tx_full_ff & ~rx_avail_ff, // R2
                    brk_ff, frame_ff, parity_ff, over_ff, rx_avail_ff};
  assign msr_val = {mdm_now, delta_ff}; // R24

  // Sources follow their enables; the line source watches bits 3 to 0.
  assign line_src = ier_ff[usm_pkg::IER_LINE] && (|lsr_val[3:0]); // R9
  assign rx_src = ier_ff[usm_pkg::IER_RX] && rx_avail_ff; // R11
  assign tx_src = ier_ff[usm_pkg::IER_TX] && tx_int_ff; // R10
  assign modem_src = ier_ff[usm_pkg::IER_MODEM] && (|delta_ff); // R8
  assign any_src = line_src | rx_src | tx_src | modem_src;

  always_comb begin
    if (line_src) begin
      iid_code = usm_pkg::IID_LINE; // R12
    end else if (rx_src) begin
      iid_code = usm_pkg::IID_RX; // R13
    end else if (tx_src) begin
      iid_code = usm_pkg::IID_TX; // R14
    end else begin
      iid_code = usm_pkg::IID_MODEM; // R12
    end
  end

  always_comb begin
    case (addr_i)
      usm_pkg::ADDR_DATA: rd_mux = rx_buf_ff;
      usm_pkg::ADDR_IER: rd_mux = {4'h0, ier_ff};
      usm_pkg::ADDR_IID: rd_mux = {5'h00, iid_code, ~any_src}; // R12
      usm_pkg::ADDR_LCR: rd_mux = lcr_ff;
      usm_pkg::ADDR_MCR: rd_mux = {3'h0, mcr_ff};
      usm_pkg::ADDR_LSR: rd_mux = lsr_val;
      usm_pkg::ADDR_MSR: rd_mux = msr_val;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    nxt_rdata = rd_stb_i ? rd_mux : 8'h00;
    nxt_ier = ier_ff;
    nxt_lcr = lcr_ff;
    nxt_mcr = mcr_ff;
    if (wr_stb_i && (addr_i == usm_pkg::ADDR_IER)) begin
      nxt_ier = wdata_i[3:0];
    end
    if (wr_stb_i && (addr_i == usm_pkg::ADDR_LCR)) begin
      nxt_lcr = wdata_i;
    end
    if (wr_stb_i && (addr_i == usm_pkg::ADDR_MCR)) begin
      nxt_mcr = wdata_i[4:0];
    end
    // A write in the same cycle as a take loads the next character.
    nxt_tx_data = wr_tx ? wdata_i : tx_data_ff;
    nxt_tx_full = wr_tx ? 1'b1 : (tx_take_i ? 1'b0 : tx_full_ff); // R1
    // The empty event sets; write or ident read clears; set wins over an ident read, a write blocks the set.
    if (tx_take_i && tx_full_ff && !wr_tx) begin
      nxt_tx_int = 1'b1; // R10
    end else if (wr_tx || rd_iid) begin
      nxt_tx_int = 1'b0; // R14
    end else begin
      nxt_tx_int = tx_int_ff;
    end
    nxt_rx_buf = rx_evt_i.valid ? rx_evt_i.data : rx_buf_ff;
    nxt_rx_avail = rx_evt_i.valid ? 1'b1 : (rd_rx ? 1'b0 : rx_avail_ff); // R7
    // Error flags: event sets, line status read clears, set wins.
    nxt_over = (rx_evt_i.valid && rx_avail_ff && !rd_rx) ? 1'b1 // R6
             : (rd_lsr ? 1'b0 : over_ff); // R25
    nxt_frame = (rx_evt_i.valid && !rx_evt_i.stop_ok) ? 1'b1 // R4 R22
              : (rd_lsr ? 1'b0 : frame_ff); // R25
    nxt_parity = (rx_evt_i.valid && rx_evt_i.parity_bad
                  && lcr_ff[usm_pkg::LCR_PAR]) ? 1'b1 // R5 R23
               : (rd_lsr ? 1'b0 : parity_ff); // R25
    nxt_brk = brk_evt ? 1'b1 : (rd_lsr ? 1'b0 : brk_ff); // R3 R25
    nxt_prev = mdm_now;
    nxt_delta = change | (rd_msr ? 4'h0 : delta_ff); // R18 R19 R20 R21
    // Pin levels follow the next register value, so they settle with it.
    nxt_txd = nxt_mcr[usm_pkg::MCR_LOOP] | tx_serial_i; // R15
    nxt_rts_n = ~nxt_mcr[usm_pkg::MCR_RTS]; // R16
    nxt_dtr_n = ~nxt_mcr[usm_pkg::MCR_DTR]; // R17
    nxt_aux1_n = ~nxt_mcr[usm_pkg::MCR_AUX1];
    nxt_aux2_n = ~nxt_mcr[usm_pkg::MCR_AUX2];
    // One cycle behind the sources, so the pin never glitches.
    nxt_irq_n = ~any_src;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= usm_pkg::BYTE_RST;
      ier_ff <= usm_pkg::IER_RST;
      lcr_ff <= usm_pkg::LCR_RST;
      mcr_ff <= usm_pkg::MCR_RST;
      tx_data_ff <= usm_pkg::BYTE_RST;
      tx_full_ff <= 1'b0;
      tx_int_ff <= 1'b0;
      rx_buf_ff <= usm_pkg::BYTE_RST;
      rx_avail_ff <= 1'b0;
      over_ff <= 1'b0;
      frame_ff <= 1'b0;
      parity_ff <= 1'b0;
      brk_ff <= 1'b0;
      prev_ff <= usm_pkg::STATE_RST;
      delta_ff <= usm_pkg::STATE_RST;
      txd_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      aux1_n_ff <= 1'b1;
      aux2_n_ff <= 1'b1;
      irq_n_ff <= 1'b1;
    end else if (ce_i) begin
      rdata_ff <= nxt_rdata;
      ier_ff <= nxt_ier;
      lcr_ff <= nxt_lcr;
      mcr_ff <= nxt_mcr;
      tx_data_ff <= nxt_tx_data;
      tx_full_ff <= nxt_tx_full;
      tx_int_ff <= nxt_tx_int;
      rx_buf_ff <= nxt_rx_buf;
      rx_avail_ff <= nxt_rx_avail;
      over_ff <= nxt_over;
      frame_ff <= nxt_frame;
      parity_ff <= nxt_parity;
      brk_ff <= nxt_brk;
      prev_ff <= nxt_prev;
      delta_ff <= nxt_delta;
      txd_ff <= nxt_txd;
      rts_n_ff <= nxt_rts_n;
      dtr_n_ff <= nxt_dtr_n;
      aux1_n_ff <= nxt_aux1_n;
      aux2_n_ff <= nxt_aux2_n;
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign rdata_o = rdata_ff;
  assign tx_data_o = tx_data_ff;
  assign tx_full_o = tx_full_ff;
  assign rx_serial_o = rx_serial_ff;
  assign line_ctrl_o = lcr_ff;
  assign serial_out_pin_o = txd_ff;
  assign rts_n_o = rts_n_ff;
  assign dtr_n_o = dtr_n_ff;
  assign aux_output_one_n_o = aux1_n_ff;
  assign aux_output_two_n_o = aux2_n_ff;
  assign irq_pending_n_o = irq_n_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_tx_write_full: assert property ( // R1
    ce_i && wr_tx |=> tx_full_o && !lsr_val[6])
    else $error("holding write did not clear empty status");
  a_both_empty: assert property ( // R2
    ce_i && (wr_tx || rx_evt_i.valid) |=> !lsr_val[5])
    else $error("both-empty status survived new data");
  a_rx_read_clear: assert property ( // R7
    ce_i && rd_rx && !rx_evt_i.valid |=> !lsr_val[0])
    else $error("data ready survived a buffer read");
  a_overrun_set: assert property ( // R6
    ce_i && rx_evt_i.valid && rx_avail_ff && !rd_rx |=> lsr_val[1])
    else $error("overwrite did not raise overrun");
  a_frame_set: assert property ( // R4
    ce_i && rx_evt_i.valid && !rx_evt_i.stop_ok |=> lsr_val[3])
    else $error("bad stop bit did not raise framing fault");
  a_parity_gate: assert property ( // R23
    ce_i && !parity_ff && !lcr_ff[usm_pkg::LCR_PAR] |=> !parity_ff)
    else $error("parity fault raised with parity off");
  a_lsr_read_clear: assert property ( // R25
    ce_i && rd_lsr && !rx_evt_i.valid && !brk_evt |=> lsr_val[4:1] == 4'h0)
    else $error("error flags survived line status read");
  a_msr_read_clear: assert property ( // R18
    ce_i && rd_msr && change == 4'h0 |=> delta_ff == 4'h0)
    else $error("modem deltas survived status read");
  a_idle_ident: assert property ( // R12
    ce_i && rd_iid && !any_src |=> rdata_o == 8'h01)
    else $error("idle ident did not read 01");
  a_line_first: assert property ( // R12
    ce_i && rd_iid && line_src |=> rdata_o == 8'h06)
    else $error("line source not reported first");
  a_iid_clear_tx: assert property ( // R14
    ce_i && rd_iid && !tx_take_i |=> !tx_int_ff)
    else $error("ident read did not clear transmit source");
  a_rts_invert: assert property ( // R16
    rts_n_o == !mcr_ff[usm_pkg::MCR_RTS])
    else $error("request-to-send not the inverse of its bit");
  a_dtr_invert: assert property ( // R17
    dtr_n_o == !mcr_ff[usm_pkg::MCR_DTR])
    else $error("terminal-ready not the inverse of its bit");
  a_loop_high: assert property ( // R15
    mcr_ff[usm_pkg::MCR_LOOP] |-> serial_out_pin_o)
    else $error("serial out not held high in loop mode");
  a_break_set: assert property ( // R3
    ce_i && brk_evt |=> brk_ff ##0 brk_cnt_ff == char_limit + 4'h1)
    else $error("break not flagged past the longest character");
  a_irq_follow: assert property ( // R8
    ce_i && modem_src |=> !irq_pending_n_o)
    else $error("modem source did not request an interrupt");
  a_line_irq: assert property ( // R9
    ce_i && line_src |=> !irq_pending_n_o)
    else $error("line source did not request an interrupt");
  a_rx_irq: assert property ( // R11
    ce_i && rx_src |=> !irq_pending_n_o)
    else $error("receive source did not request an interrupt");
  // With every source quiet the request must fall away again.
  a_idle_irq: assert property ( // R12
    ce_i && !any_src |=> irq_pending_n_o)
    else $error("interrupt requested with nothing pending");
  a_tx_empty_set: assert property ( // R10
    ce_i && tx_take_i && tx_full_ff && !wr_tx |=> tx_int_ff)
    else $error("take of a full holding did not raise source");
  a_rx_full_code: assert property ( // R13
    ce_i && rd_iid && rx_src && !line_src |=> rdata_o == 8'h04)
    else $error("receive source not reported as code 10");
  a_tx_empty_code: assert property ( // R14
    ce_i && rd_iid && tx_src && !line_src && !rx_src |=> rdata_o == 8'h02)
    else $error("transmit source not reported as code 01");
  a_carrier_delta: assert property ( // R18
    ce_i && (prev_ff[3] != mdm_now[3]) |=> delta_ff[3])
    else $error("carrier change not recorded");
  a_ring_trail: assert property ( // R19
    ce_i && prev_ff[2] && !mdm_now[2] |=> delta_ff[2])
    else $error("ring trailing edge not recorded");
  a_loop_route: assert property ( // R15
    mcr_ff[usm_pkg::MCR_LOOP] |-> msr_val[4] == mcr_ff[usm_pkg::MCR_RTS]
      && msr_val[5] == mcr_ff[usm_pkg::MCR_DTR])
    else $error("loop did not route control bits to status");
  // Outside loop mode the live bits are the inverted, synchronised pins.
  a_msr_current: assert property ( // R24
    !mcr_ff[usm_pkg::MCR_LOOP] |-> msr_val[7:4] == ~mdm_sync_ff)
    else $error("modem status does not show the pin states");

  c_overrun: cover property (ce_i && rx_evt_i.valid && rx_avail_ff);
  c_tx_ident: cover property (rd_iid && tx_src);
  c_break: cover property (brk_evt);
  c_loop_ring: cover property (mcr_ff[usm_pkg::MCR_LOOP] && change[2]);
  c_line_ident: cover property (rd_iid && line_src);

endmodule // usm_core

/* verif/usm_modem_model.sv */
`timescale 1ns/1ps
module usm_modem_model (
  // Clock
  input wire logic clk_i,
  // Line states asked for by the bench, active high
  input wire usm_pkg::usm_modem_t want_i,
  input wire logic brk_i,
  // Pins toward the port
  output usm_pkg::usm_modem_t pins_n_o,
  output logic line_o
);
  // Lines idle deasserted and the serial line idles high, as a real
  // peripheral leaves them when it has nothing to say.
  initial begin
    pins_n_o = usm_pkg::PINS_RST;
    line_o = 1'b1;
    forever begin
      @(posedge clk_i);
      pins_n_o <= usm_pkg::usm_modem_t'(~want_i);
      line_o <= ~brk_i;
    end
  end
endmodule // usm_modem_model

/* verif/test_usm_core.sv */
`timescale 1ns/1ps
module test_usm_core;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_stb_i = 1'b0;
  logic rd_stb_i = 1'b0;
  logic tx_take_i = 1'b0;
  logic tx_serial_i = 1'b0;
  logic bit_tick_i = 1'b0;
  logic brk = 1'b0;
  logic ce = 1'b1;
  usm_pkg::usm_rx_evt_t rx_evt_i = '0;
  usm_pkg::usm_modem_t want = '0;
  usm_pkg::usm_modem_t pins_n;
  logic ser_in, rx_ser, ser_out, rts_n, dtr_n, aux1_n, aux2_n, irq_n, tx_full;
  logic [7:0] rdata, tx_data, lcr, rd;
  int err_total = 0;
  int tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  usm_core i_usm_core (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_stb_i(wr_stb_i),
    .rd_stb_i(rd_stb_i), .rdata_o(rdata), .tx_take_i(tx_take_i),
    .tx_serial_i(tx_serial_i), .tx_data_o(tx_data), .tx_full_o(tx_full),
    .rx_evt_i(rx_evt_i), .bit_tick_i(bit_tick_i), .rx_serial_o(rx_ser),
    .line_ctrl_o(lcr), .serial_in_pin_i(ser_in), .modem_pins_n_i(pins_n),
    .serial_out_pin_o(ser_out), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .aux_output_one_n_o(aux1_n), .aux_output_two_n_o(aux2_n),
    .irq_pending_n_o(irq_n));
  usm_modem_model i_usm_modem_model (.clk_i(clk_i), .want_i(want),
    .brk_i(brk), .pins_n_o(pins_n), .line_o(ser_in));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_stb_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_stb_i <= 1'b0;
  endtask
  task automatic exp_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_stb_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
    #1;
    rd = rdata;
    check8($sformatf("reg %0d", a), e, rd);
  endtask
  task automatic irq_is(input logic e);
    idle(2);
    check8("irq_n", {7'h00, e}, {7'h00, irq_n});
  endtask
  task automatic pulse_take;
    @(posedge clk_i);
    tx_take_i <= 1'b1;
    @(posedge clk_i);
    tx_take_i <= 1'b0;
  endtask
  task automatic rx_push(input logic [7:0] d, input logic ok, input logic pb);
    @(posedge clk_i);
    rx_evt_i <= '{1'b1, d, ok, pb};
    @(posedge clk_i);
    rx_evt_i <= '0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      bit_tick_i <= 1'b1;
      @(posedge clk_i);
      bit_tick_i <= 1'b0;
    end
    idle(2);
  endtask
  task automatic set_pins(input usm_pkg::usm_modem_t v);
    @(posedge clk_i);
    want <= v;
    idle(6);
  endtask
  task automatic t_reset;
    exp_rd(usm_pkg::ADDR_IER, 8'h00);
    exp_rd(usm_pkg::ADDR_IID, 8'h01);
    exp_rd(usm_pkg::ADDR_MCR, 8'h00);
    exp_rd(usm_pkg::ADDR_LSR, 8'h60);
    exp_rd(usm_pkg::ADDR_MSR, 8'h00);
    // The unmapped index must swallow writes and read as zero.
    wr(3'h7, 8'hFF);
    exp_rd(3'h7, 8'h00);
    // A frozen block must ignore a write made while the enable is low.
    @(posedge clk_i);
    ce <= 1'b0;
    wr(usm_pkg::ADDR_MCR, 8'h13);
    @(posedge clk_i);
    ce <= 1'b1;
    exp_rd(usm_pkg::ADDR_MCR, 8'h00);
    irq_is(1'b1);
    $display("test reset done");
  endtask
  task automatic t_modem_ctrl;
    wr(usm_pkg::ADDR_MCR, 8'h02);
    idle(1);
    check8("rts dtr", 8'h01, {6'h00, rts_n, dtr_n});
    wr(usm_pkg::ADDR_MCR, 8'h01);
    idle(1);
    check8("rts dtr", 8'h02, {6'h00, rts_n, dtr_n});
    wr(usm_pkg::ADDR_MCR, 8'h1F);
    idle(6);
    check8("pins", 8'h10,
           {2'h0, rx_ser, ser_out, rts_n, dtr_n, aux1_n, aux2_n});
    exp_rd(usm_pkg::ADDR_MSR, 8'hFB);
    wr(usm_pkg::ADDR_MCR, 8'h00);
    idle(6);
    exp_rd(usm_pkg::ADDR_MSR, 8'h0F);
    check8("pins", 8'h2F,
           {2'h0, rx_ser, ser_out, rts_n, dtr_n, aux1_n, aux2_n});
    // Outside loop mode the pin follows the shifter, the receiver the pin.
    @(posedge clk_i);
    tx_serial_i <= 1'b1;
    idle(2);
    check8("serial path", 8'h03, {6'h00, rx_ser, ser_out});
    $display("test modem control done");
  endtask
  task automatic t_modem_status;
    set_pins(4'h8);
    exp_rd(usm_pkg::ADDR_MSR, 8'h88);
    exp_rd(usm_pkg::ADDR_MSR, 8'h80);
    set_pins(4'hC);
    exp_rd(usm_pkg::ADDR_MSR, 8'hC0);
    set_pins(4'h8);
    exp_rd(usm_pkg::ADDR_MSR, 8'h84);
    set_pins(4'hB);
    exp_rd(usm_pkg::ADDR_MSR, 8'hB3);
    wr(usm_pkg::ADDR_IER, 8'h08);
    set_pins(4'h0);
    irq_is(1'b0);
    exp_rd(usm_pkg::ADDR_IID, 8'h00);
    exp_rd(usm_pkg::ADDR_MSR, 8'h0B);
    irq_is(1'b1);
    wr(usm_pkg::ADDR_IER, 8'h00);
    $display("test modem status done");
  endtask
  task automatic t_rx;
    wr(usm_pkg::ADDR_IER, 8'h01);
    rx_push(8'h5A, 1'b1, 1'b0);
    exp_rd(usm_pkg::ADDR_LSR, 8'h41);
    irq_is(1'b0);
    exp_rd(usm_pkg::ADDR_IID, 8'h04);
    exp_rd(usm_pkg::ADDR_DATA, 8'h5A);
    exp_rd(usm_pkg::ADDR_LSR, 8'h60);
    irq_is(1'b1);
    $display("test receive done");
  endtask
  task automatic t_rx_err;
    wr(usm_pkg::ADDR_LCR, 8'h08);
    wr(usm_pkg::ADDR_IER, 8'h04);
    idle(1);
    check8("line ctrl", 8'h08, lcr);
    rx_push(8'hA5, 1'b0, 1'b1);
    rx_push(8'h3C, 1'b1, 1'b0);
    irq_is(1'b0);
    exp_rd(usm_pkg::ADDR_IID, 8'h06);
    exp_rd(usm_pkg::ADDR_LSR, 8'h4F);
    exp_rd(usm_pkg::ADDR_LSR, 8'h41);
    exp_rd(usm_pkg::ADDR_DATA, 8'h3C);
    wr(usm_pkg::ADDR_LCR, 8'h00);
    rx_push(8'h11, 1'b1, 1'b1);
    exp_rd(usm_pkg::ADDR_LSR, 8'h41);
    exp_rd(usm_pkg::ADDR_DATA, 8'h11);
    wr(usm_pkg::ADDR_IER, 8'h00);
    $display("test receive errors done");
  endtask
  task automatic t_tx;
    wr(usm_pkg::ADDR_IER, 8'h02);
    wr(usm_pkg::ADDR_DATA, 8'h33);
    idle(1);
    check8("tx data", 8'h33, tx_data);
    exp_rd(usm_pkg::ADDR_LSR, 8'h00);
    pulse_take;
    irq_is(1'b0);
    exp_rd(usm_pkg::ADDR_LSR, 8'h60);
    exp_rd(usm_pkg::ADDR_IID, 8'h02);
    exp_rd(usm_pkg::ADDR_IID, 8'h01);
    wr(usm_pkg::ADDR_DATA, 8'h44);
    pulse_take;
    irq_is(1'b0);
    wr(usm_pkg::ADDR_DATA, 8'h55);
    irq_is(1'b1);
    check8("tx full", 8'h01, {7'h00, tx_full});
    pulse_take;
    exp_rd(usm_pkg::ADDR_IID, 8'h02);
    wr(usm_pkg::ADDR_IER, 8'h00);
    $display("test transmit done");
  endtask
  task automatic brk_run(input logic [7:0] lc, input int n);
    wr(usm_pkg::ADDR_LCR, lc);
    @(posedge clk_i);
    brk <= 1'b1;
    idle(4);
    tick(n - 1);
    exp_rd(usm_pkg::ADDR_LSR, 8'h60);
    tick(1);
    exp_rd(usm_pkg::ADDR_LSR, 8'h70);
    tick(3);
    exp_rd(usm_pkg::ADDR_LSR, 8'h60);
    @(posedge clk_i);
    brk <= 1'b0;
    idle(4);
  endtask
  task automatic t_break;
    // Five-bit words, one stop, no parity: the flag lands on tick eight.
    brk_run(8'h00, 8);
    // Eight bits, parity and two stops make twelve: flag on tick 13.
    brk_run(8'h0F, 13);
    wr(usm_pkg::ADDR_LCR, 8'h00);
    $display("test break done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset;
    t_modem_ctrl;
    t_modem_status;
    t_rx;
    t_rx_err;
    t_tx;
    t_break;
    tally_and_finish;
  end
endmodule // test_usm_core
